// File: src/eiu_core.sv
// Implementation choices: the AHB-Lite register port and the address map.
module eiu_core
	import eiu_pkg::*;
(
	input wire logic hclk, // Core clock
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write access
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic nmi_pin_n, // Non-maskable request pin
	input wire logic request_level_three_n, // Maskable request three
	input wire logic request_level_two_n, // Maskable request two
	input wire logic request_level_one_n, // Maskable request one
	input wire logic instr_end_next, // Next cycle is a first fetch
	input wire logic div_zero, // Divide by zero just executed
	input wire logic trap_req, // Trap instruction executed
	input wire logic [7:0] trap_operand, // Trap vector address
	input wire logic flag_write_instr, // Instruction writes flags or bank
	input wire logic exception_return, // Exception return executed
	input wire logic [1:0] return_mask, // Mask popped from stack
	input wire logic [7:0] vector_bus_in, // Vector address from peripheral
	input wire logic [7:0] mem_rd_data, // Vector memory byte
	output logic first_fetch_marker, // First opcode fetch cycle
	output logic exception_acknowledge_n, // Exception sequence active
	output logic vector_read_strobe, // Peripheral vector read
	output logic mem_rd_req, // Vector memory read
	output logic [15:0] mem_rd_addr, // Vector memory address
	output logic push_req, // Stack push request
	output logic push_flags, // Push carries flags, not PC
	output logic [1:0] push_mask, // Mask level to stack
	output logic pc_load, // Load program counter
	output logic [15:0] program_counter, // Routine start address
	output logic mask_level_high_bit, // Mask level bit 1
	output logic mask_level_low_bit // Mask level bit 0
);

	eiu_state_t st_r, st_nxt;
	eiu_cause_t cause_r, sel;
	logic [3:0] pin_n, pin_s;
	logic nmi_d_r, nmi_fall, nmi_pend_r, div_pend_r, trap_pend_r;
	logic reset_pend_r, boot_r, hold_r, sync_r, take, is_irq;
	logic [2:0] irq_lvl;
	logic [1:0] mask_r;
	logic [7:0] trap_vec_r, vec_byte_r, pc_lo_r;
	logic [15:0] pc_r, rd_addr_r;
	logic ack_n_r, vread_r, rd_req_r, push_r, pflags_r, pcl_r;
	logic [1:0] pmask_r;
	logic wr_pend_r, sw_wr, ap, hready_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Two-flop synchronisers on the request pins
	assign pin_n = {nmi_pin_n, request_level_three_n,
		request_level_two_n, request_level_one_n};
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			logic m_r, s_r;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					m_r <= 1'b1;
					s_r <= 1'b1;
				end else begin
					m_r <= pin_n[g];
					s_r <= m_r;
				end
			end
			assign pin_s[g] = s_r;
		end
	endgenerate

	// Edge detect reads only synchronised levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			nmi_d_r <= 1'b1;
		else
			nmi_d_r <= pin_s[3];
	end
	assign nmi_fall = nmi_d_r & ~pin_s[3];
	assign irq_lvl = ~pin_s[2:0];

	// Fixed priority pick; hold-off only gates interrupts
	always_comb begin
		sel = CS_NONE;
		if (reset_pend_r)
			sel = CS_RESET;
		else if (div_pend_r)
			sel = CS_ZDIV;
		else if (nmi_pend_r && !hold_r)
			sel = CS_NMI;
		else if (irq_lvl[2] && mask_r < LVL_REQUEST_LEVEL_THREE_N && !hold_r)
			sel = CS_REQUEST_LEVEL_THREE_N;
		else if (irq_lvl[1] && mask_r < LVL_REQUEST_LEVEL_TWO_N && !hold_r)
			sel = CS_REQUEST_LEVEL_TWO_N;
		else if (irq_lvl[0] && mask_r < LVL_REQUEST_LEVEL_ONE_N && !hold_r)
			sel = CS_REQUEST_LEVEL_ONE_N;
		else if (trap_pend_r)
			sel = CS_TRAP;
	end
	assign take = sync_r && (st_r == ST_RUN) && (sel != CS_NONE);
	assign is_irq = (cause_r == CS_REQUEST_LEVEL_THREE_N) || (cause_r == CS_REQUEST_LEVEL_TWO_N) ||
		(cause_r == CS_REQUEST_LEVEL_ONE_N);

	// Pending factors; a new event beats its own clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_pend_r <= 1'b0;
			div_pend_r <= 1'b0;
			trap_pend_r <= 1'b0;
			reset_pend_r <= 1'b1;
			trap_vec_r <= VBYTE_RESET;
		end else begin
			if (nmi_fall)
				nmi_pend_r <= 1'b1;
			else if (take && sel == CS_NMI)
				nmi_pend_r <= 1'b0;
			if (div_zero)
				div_pend_r <= 1'b1;
			else if (take && sel == CS_ZDIV)
				div_pend_r <= 1'b0;
			if (trap_req) begin
				trap_pend_r <= 1'b1;
				trap_vec_r <= trap_operand;
			end else if (take && sel == CS_TRAP)
				trap_pend_r <= 1'b0;
			if (take && sel == CS_RESET)
				reset_pend_r <= 1'b0;
		end
	end

	// Hold-off spans the boundary that ends a flag-writing instruction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hold_r <= 1'b0;
		else if (flag_write_instr || sw_wr)
			hold_r <= 1'b1;
		else if (sync_r)
			hold_r <= 1'b0;
	end

	// Sequencer next state
	always_comb begin
		case (st_r)
			ST_RUN: st_nxt = take ? ST_ACK : ST_RUN;
			ST_ACK: begin
				if (is_irq)
					st_nxt = ST_VADDR;
				else if (cause_r == CS_RESET)
					st_nxt = ST_VLO;
				else
					st_nxt = ST_PUSH_PC;
			end
			ST_VADDR: st_nxt = ST_PUSH_PC;
			ST_PUSH_PC: st_nxt = ST_PUSH_SC;
			ST_PUSH_SC: st_nxt = ST_VLO;
			ST_VLO: st_nxt = ST_VHI;
			ST_VHI: st_nxt = ST_LOAD;
			ST_LOAD: st_nxt = ST_RUN;
			default: st_nxt = ST_RUN;
		endcase
	end

	// State, cause and vector byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= ST_RUN;
			cause_r <= CS_NONE;
			vec_byte_r <= VBYTE_RESET;
		end else begin
			st_r <= st_nxt;
			if (take) begin
				cause_r <= sel;
				case (sel)
					CS_RESET: vec_byte_r <= VEC_RESET;
					CS_ZDIV: vec_byte_r <= VEC_ZDIV;
					CS_NMI: vec_byte_r <= VEC_NMI;
					CS_TRAP: vec_byte_r <= trap_vec_r;
					default: vec_byte_r <= vec_byte_r;
				endcase
			end else if (st_r == ST_VADDR)
				vec_byte_r <= vector_bus_in;
		end
	end

	// First-fetch marker: after reset, after a branch, or at an end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_r <= 1'b1;
			sync_r <= 1'b0;
		end else begin
			boot_r <= 1'b0;
			sync_r <= (st_nxt == ST_RUN) && (boot_r ||
				st_r == ST_LOAD || instr_end_next);
		end
	end

	// Bus-side strobes of the sequence, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_n_r <= 1'b1;
			vread_r <= 1'b0;
			rd_req_r <= 1'b0;
			rd_addr_r <= PC_RESET;
			push_r <= 1'b0;
			pflags_r <= 1'b0;
			pmask_r <= MASK_RESET;
		end else begin
			ack_n_r <= (st_nxt == ST_RUN);
			vread_r <= (st_nxt == ST_VADDR);
			rd_req_r <= (st_nxt == ST_VLO) || (st_nxt == ST_VHI);
			rd_addr_r <= {VEC_PAGE, (st_nxt == ST_VHI) ?
				8'(vec_byte_r + 8'h01) : vec_byte_r};
			push_r <= (st_nxt == ST_PUSH_PC) ||
				(st_nxt == ST_PUSH_SC);
			pflags_r <= (st_nxt == ST_PUSH_SC);
			pmask_r <= mask_r;
		end
	end

	// Vector capture; the code bank is never touched here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_lo_r <= VBYTE_RESET;
			pc_r <= PC_RESET;
			pcl_r <= 1'b0;
		end else begin
			if (st_r == ST_VLO)
				pc_lo_r <= mem_rd_data;
			if (st_r == ST_VHI)
				pc_r <= {mem_rd_data, pc_lo_r};
			pcl_r <= (st_nxt == ST_LOAD);
		end
	end

	// Mask: sequencer after flag push, then return, then software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mask_r <= MASK_RESET;
		else if (st_r == ST_PUSH_SC) begin
			case (cause_r)
				CS_NMI: mask_r <= MASK_ON_NMI;
				CS_REQUEST_LEVEL_THREE_N: mask_r <= MASK_ON_REQUEST_LEVEL_THREE_N;
				CS_REQUEST_LEVEL_TWO_N: mask_r <= MASK_ON_REQUEST_LEVEL_TWO_N;
				CS_REQUEST_LEVEL_ONE_N: mask_r <= MASK_ON_REQUEST_LEVEL_ONE_N;
				default: mask_r <= mask_r;
			endcase
		end else if (exception_return)
			mask_r <= return_mask;
		else if (sw_wr)
			mask_r <= hwdata[1:0];
	end

	// Bus slave: zero wait states, write lands in the data phase
	assign ap = hsel && htrans[1] && hready;
	assign sw_wr = wr_pend_r && (wr_addr_r == OFS_CTRL);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= OFS_CTRL;
			hrdata_r <= RDATA_RESET;
			hready_r <= 1'b1;
		end else begin
			hready_r <= 1'b1;
			wr_pend_r <= ap && hwrite;
			wr_addr_r <= haddr[7:0];
			hrdata_r <= RDATA_RESET;
			if (ap && !hwrite) begin
				case (haddr[7:0])
					OFS_CTRL: hrdata_r <= {30'h0000_0000, mask_r};
					OFS_STATUS: hrdata_r <= {13'h0000, irq_lvl,
						reset_pend_r, trap_pend_r, div_pend_r,
						nmi_pend_r, hold_r, cause_r, st_r};
					OFS_VECTOR: hrdata_r <= {16'h0000, pc_r};
					default: hrdata_r <= RDATA_RESET;
				endcase
			end
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hready_r;
	assign hresp = 1'b0;
	assign first_fetch_marker = sync_r;
	assign exception_acknowledge_n = ack_n_r;
	assign vector_read_strobe = vread_r;
	assign mem_rd_req = rd_req_r;
	assign mem_rd_addr = rd_addr_r;
	assign push_req = push_r;
	assign push_flags = pflags_r;
	assign push_mask = pmask_r;
	assign pc_load = pcl_r;
	assign program_counter = pc_r;
	assign mask_level_high_bit = mask_r[1];
	assign mask_level_low_bit = mask_r[0];

	// Checks on the sequence
	sequence s_reset_path;
		st_r == ST_VLO ##1 st_r == ST_VHI ##1 st_r == ST_LOAD;
	endsequence
	sequence s_irq_path;
		st_r == ST_VADDR ##1 st_r == ST_PUSH_PC ##1 st_r == ST_PUSH_SC
			##1 st_r == ST_VLO ##1 st_r == ST_VHI ##1 st_r == ST_LOAD;
	endsequence

	chk_marker_follows_end: assert property (
		st_r == ST_RUN && !take && instr_end_next |=> sync_r)
		else $error("marker missing after instruction end");
	chk_ack_on_take: assert property (
		take |=> !exception_acknowledge_n && st_r == ST_ACK)
		else $error("acknowledge not raised on accepted factor");
	chk_reset_no_push: assert property (
		st_r == ST_ACK && cause_r == CS_RESET |=> s_reset_path
			##0 !push_req && pc_load ##1 first_fetch_marker)
		else $error("reset sequence wrong or pushed state");
	chk_irq_path_order: assert property (
		st_r == ST_ACK && is_irq |=> s_irq_path)
		else $error("maskable request sequence out of order");
	chk_vread_only_irq: assert property (
		vector_read_strobe |-> is_irq && !mem_rd_req)
		else $error("vector strobe outside maskable request");
	chk_mask_after_push: assert property (
		$changed(mask_r) && !$past(exception_return) && !$past(sw_wr)
			|-> $past(st_r) == ST_PUSH_SC && $past(push_flags))
		else $error("mask changed before flags were pushed");
	chk_nmi_always_taken: assert property (
		sync_r && nmi_pend_r && !hold_r && !reset_pend_r && !div_pend_r
			|=> cause_r == CS_NMI && !exception_acknowledge_n)
		else $error("pending NMI not accepted");
	chk_request_level_one_n_masked: assert property (
		sync_r && mask_r != 2'h0 && irq_lvl == 3'h1 && !nmi_pend_r &&
			!reset_pend_r && !div_pend_r && !trap_pend_r |=> st_r == ST_RUN)
		else $error("level one accepted while masked");
	chk_request_level_two_n_mask_set: assert property (
		st_r == ST_PUSH_SC && cause_r == CS_REQUEST_LEVEL_TWO_N |=> mask_r == 2'h2)
		else $error("mask not set to level two");
	chk_holdoff_blocks: assert property (
		sync_r && hold_r && !reset_pend_r && !div_pend_r && !trap_pend_r
			|=> st_r == ST_RUN)
		else $error("interrupt taken during hold-off");

endmodule // eiu_core

// File: src/eiu_pkg.sv
package eiu_pkg;

	// Exception sequencer states, one-hot
	typedef enum logic [7:0] {
		ST_RUN     = 8'h01,
		ST_ACK     = 8'h02,
		ST_VADDR   = 8'h04,
		ST_PUSH_PC = 8'h08,
		ST_PUSH_SC = 8'h10,
		ST_VLO     = 8'h20,
		ST_VHI     = 8'h40,
		ST_LOAD    = 8'h80
	} eiu_state_t;

	// Accepted exception cause
	typedef enum logic [2:0] {
		CS_NONE  = 3'h0,
		CS_RESET = 3'h1,
		CS_ZDIV  = 3'h2,
		CS_NMI   = 3'h3,
		CS_REQUEST_LEVEL_THREE_N  = 3'h4,
		CS_REQUEST_LEVEL_TWO_N  = 3'h5,
		CS_REQUEST_LEVEL_ONE_N  = 3'h6,
		CS_TRAP  = 3'h7
	} eiu_cause_t;

	// Fixed vector locations (low byte of a two-byte vector)
	localparam logic [7:0] VEC_RESET = 8'h00;
	localparam logic [7:0] VEC_ZDIV = 8'h02;
	localparam logic [7:0] VEC_NMI = 8'h04;
	localparam logic [7:0] VEC_PAGE = 8'h00;

	// Mask levels: acceptance thresholds and values set on acceptance
	localparam logic [1:0] MASK_RESET = 2'h3;
	localparam logic [1:0] LVL_REQUEST_LEVEL_THREE_N = 2'h3;
	localparam logic [1:0] LVL_REQUEST_LEVEL_TWO_N = 2'h2;
	localparam logic [1:0] LVL_REQUEST_LEVEL_ONE_N = 2'h1;
	localparam logic [1:0] MASK_ON_NMI = 2'h3;
	localparam logic [1:0] MASK_ON_REQUEST_LEVEL_THREE_N = 2'h3;
	localparam logic [1:0] MASK_ON_REQUEST_LEVEL_TWO_N = 2'h2;
	localparam logic [1:0] MASK_ON_REQUEST_LEVEL_ONE_N = 2'h1;

	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_VECTOR = 8'h08;

	// Reset values
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] VBYTE_RESET = 8'h00;

endpackage

// File: verif/eiu_periph.sv
module eiu_periph (
	input wire logic hclk, // Core clock
	input wire logic hresetn, // Reset, active low
	input wire logic [3:0] want, // Wanted requests {nmi,3,2,1}
	input wire logic exception_acknowledge_n, // Sequence active, low
	input wire logic vector_read_strobe, // Vector read cycle
	output logic nmi_pin_n, // Falls when nmi is wanted
	output logic request_level_three_n, // Level three line
	output logic request_level_two_n, // Level two line
	output logic request_level_one_n, // Level one line
	output logic [7:0] vector_bus_in // Vector address byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] served_r;
	logic [7:0] last_r;
	logic [2:0] live;
	logic [2:0] top;
	logic [7:0] vec;

	// Highest live line is the one the core takes
	assign live = want[2:0] & ~served_r;
	assign top = live[2] ? 3'h4 : (live[1] ? 3'h2 : {2'h0, live[0]});
	assign vec = live[2] ? 8'h50 : (live[1] ? 8'h40 : 8'h30);
	// Lines are held low until the vector read takes them
	assign request_level_three_n = ~live[2];
	assign request_level_two_n = ~live[1];
	assign request_level_one_n = ~live[0];
	assign nmi_pin_n = ~want[3];
	// Off the strobe the bus shows junk, so a late sample cannot pass
	assign vector_bus_in = (vector_read_strobe && !exception_acknowledge_n)
		? vec : ~last_r;

	// Served lines are forgotten once the bench stops wanting them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			served_r <= 3'h0;
			last_r <= 8'h00;
		end else if (vector_read_strobe && !exception_acknowledge_n) begin
			served_r <= (served_r & want[2:0]) | top;
			last_r <= vec;
		end else begin
			served_r <= served_r & want[2:0];
		end
	end
endmodule // eiu_periph

// File: verif/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, ien, dz, tr, fw, er, booted;
	logic hreadyout, hresp, nmi_n, n3, n2, n1, marker, ack_n, strobe;
	logic mreq, push, pfl, pl, mhi, mlo, ien_d, pl_d;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, rmask, mask, pmask;
	logic [2:0] hsize;
	logic [3:0] want;
	logic [7:0] op, vbus, mdat, cyc, tv;
	logic [15:0] maddr, pc;
	logic [20:0] q[$]; // {vector, new mask, old mask, pushes}
	int miscompares, check_count;

	// Vector memory answers in the cycle of the request, junk otherwise
	assign mdat = mreq ? (maddr[7:0] ^ 8'ha5) : cyc;

	eiu_core eiu_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .nmi_pin_n(nmi_n),
		.request_level_three_n(n3), .request_level_two_n(n2),
		.request_level_one_n(n1), .instr_end_next(ien), .div_zero(dz),
		.trap_req(tr), .trap_operand(op), .flag_write_instr(fw),
		.exception_return(er), .return_mask(rmask), .vector_bus_in(vbus),
		.mem_rd_data(mdat), .first_fetch_marker(marker),
		.exception_acknowledge_n(ack_n), .vector_read_strobe(strobe),
		.mem_rd_req(mreq), .mem_rd_addr(maddr), .push_req(push),
		.push_flags(pfl), .push_mask(pmask), .pc_load(pl),
		.program_counter(pc), .mask_level_high_bit(mhi),
		.mask_level_low_bit(mlo));
	eiu_periph eiu_periph_i (.hclk(hclk), .hresetn(hresetn), .want(want),
		.exception_acknowledge_n(ack_n), .vector_read_strobe(strobe),
		.nmi_pin_n(nmi_n), .request_level_three_n(n3),
		.request_level_two_n(n2), .request_level_one_n(n1),
		.vector_bus_in(vbus));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	function automatic logic [15:0] ev(input logic [7:0] v);
		return {(v + 8'h01) ^ 8'ha5, v ^ 8'ha5};
	endfunction

	task cmp(input logic [15:0] g, input logic [15:0] e, input string m);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Model: each expected branch is queued, checked at push and load
	always @(posedge hclk) begin
		cyc <= cyc + 8'h01;
		ien_d <= ien;
		pl_d <= pl;
		if (hresetn && booted)
			cmp({15'h0, marker}, {15'h0, ien_d | pl_d}, "marker");
		if (hresetn && push && q.size() > 0)
			cmp({15'h0, q[0][0]}, 16'h1, "push");
		if (hresetn && push && pfl && q.size() > 0)
			cmp({14'h0, pmask}, {14'h0, q[0][2:1]}, "old mask");
		if (hresetn && pl && q.size() == 0)
			cmp(16'h0, 16'h1, "stray branch");
		if (hresetn && pl && q.size() > 0) begin
			cmp(pc, q[0][20:5], "vector");
			cmp({14'h0, mhi, mlo}, {14'h0, q[0][4:3]}, "mask");
			void'(q.pop_front());
			booted <= 1'b1;
		end
	end

	task exp(input logic [7:0] v, input logic [1:0] nm, input logic p);
		q.push_back({ev(v), nm, mask, p});
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// One instruction boundary, with its side conditions
	task bnd(input logic z, input logic t, input logic f, input logic [7:0] o);
		ien <= 1'b1;
		dz <= z;
		tr <= t;
		fw <= f;
		op <= o;
		@(posedge hclk);
		ien <= 1'b0;
		dz <= 1'b0;
		tr <= 1'b0;
		fw <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask

	task wait_q(input string s);
		int n;
		n = 0;
		while (q.size() > 0 && n < 300) begin
			@(posedge hclk);
			n++;
		end
		if (q.size() > 0)
			cmp(16'h0, 16'h1, "no branch");
		q.delete();
		repeat (12) @(posedge hclk);
		$display("test %s ended", s);
	endtask

	// A mask write holds off one boundary, so spend an empty one
	task setm(input logic [1:0] m);
		bus(1'b1, 8'h00, {30'h0, m});
		bus(1'b0, 8'h00, 32'h0);
		cmp(rd[15:0], {14'h0, m}, "ctrl readback");
		mask = m;
		bnd(1'b0, 1'b0, 1'b0, 8'h00);
	endtask

	task ret(input logic [1:0] m);
		er <= 1'b1;
		rmask <= m;
		@(posedge hclk);
		er <= 1'b0;
		@(posedge hclk);
		cmp({14'h0, mhi, mlo}, {14'h0, m}, "return mask");
		mask = m;
		bnd(1'b0, 1'b0, 1'b0, 8'h00);
	endtask

	initial begin
		#100000;
		miscompares++;
		finish_test();
	end

	initial begin
		{hsel, hwrite, ien, dz, tr, fw, er, booted, ien_d, pl_d} = 10'h0;
		{haddr, hwdata, htrans, rmask, op, cyc, want} = 88'h0;
		hsize = 3'h2;
		hresetn = 1'b0;
		mask = 2'h3;
		void'($urandom(32'h32a0358d));
		exp(8'h00, 2'h3, 1'b0);
		repeat (12) @(posedge hclk);
		cmp({14'h0, mhi, mlo}, 16'h3, "reset mask");
		hresetn <= 1'b1;
		wait_q("reset");
		exp(8'h02, mask, 1'b1);
		bnd(1'b1, 1'b0, 1'b0, 8'h00);
		wait_q("zero divide");
		for (int i = 0; i < 4; i++) begin
			tv = 8'($urandom) & 8'hfe;
			exp(tv, mask, 1'b1);
			bnd(1'b0, 1'b1, 1'b0, tv);
			wait_q("trap");
		end
		want <= 4'h8;
		repeat (4) @(posedge hclk);
		exp(8'h04, 2'h3, 1'b1);
		bnd(1'b0, 1'b0, 1'b0, 8'h00);
		wait_q("nmi under full mask");
		want <= 4'h0;
		for (int i = 0; i < 4; i++) begin
			for (int j = 1; j < 4; j++) begin
				setm(2'(i));
				want <= 4'(1 << (j - 1));
				repeat (4) @(posedge hclk);
				if (j > i)
					exp(8'h20 + {2'(j), 4'h0}, 2'(j), 1'b1);
				bnd(1'b0, 1'b0, 1'b0, 8'h00);
				wait_q("mask table");
				want <= 4'h0;
				repeat (4) @(posedge hclk);
				if (j > i)
					ret(2'(i));
			end
		end
		setm(2'h0);
		want <= 4'hc;
		repeat (4) @(posedge hclk);
		exp(8'h02, 2'h0, 1'b1);
		exp(8'h04, 2'h3, 1'b1);
		bnd(1'b1, 1'b0, 1'b0, 8'h00);
		wait_q("priority");
		want <= 4'h4;
		exp(8'h50, 2'h3, 1'b1);
		ret(2'h0);
		wait_q("unmasked after return");
		// Level three left the mask at 11; open it again for level one
		setm(2'h0);
		want <= 4'h1;
		repeat (4) @(posedge hclk);
		bnd(1'b0, 1'b0, 1'b1, 8'h00);
		repeat (12) @(posedge hclk);
		exp(8'h30, 2'h1, 1'b1);
		bnd(1'b0, 1'b0, 1'b0, 8'h00);
		wait_q("hold off");
		want <= 4'h0;
		bus(1'b0, 8'h08, 32'h0);
		cmp(rd[15:0], ev(8'h30), "vector register");
		bus(1'b1, 8'h0c, 32'hffff_ffff);
		bus(1'b0, 8'h0c, 32'h0);
		cmp(rd[15:0], 16'h0, "unmapped read");
		bus(1'b0, 8'h04, 32'h0);
		cmp(rd[15:0], 16'h0601, "status idle");
		$display("test registers ended");
		finish_test();
	end
endmodule // tb_top
